// ---- core/mdm_defines.svh ----
`ifndef MDM_DEFINES_SVH
`define MDM_DEFINES_SVH

// Field widths and register space.
`define MDM_ADDR_W 5
`define MDM_DATA_W 16
`define MDM_NREG 32

// Frame codes, sent most significant bit first.
`define MDM_START_CODE 2'h1
`define MDM_OP_READ 2'h2
`define MDM_OP_WRITE 2'h1
`define MDM_TA_WRITE 2'h2
`define MDM_TA_READ 2'h3

// Frame layout in bit times.
`define MDM_PRE_BITS 32
`define MDM_HDR_BITS 14
`define MDM_FRAME_BITS 65
`define MDM_RD_FIRST 48
`define MDM_RD_LAST 63
`define MDM_SKIP_BITS 18

// Management clock limit and the divider derived from it.
`define MDM_CORE_KHZ 125000
`define MDM_MDC_MAX_KHZ 25000
`define MDM_MDC_DIV (2 * ((`MDM_CORE_KHZ + 2 * `MDM_MDC_MAX_KHZ - 1) / (2 * `MDM_MDC_MAX_KHZ)))
`define MDM_MDC_HALF (`MDM_MDC_DIV / 2)

// Idle management clock cycles after reset before the first frame.
`define MDM_GUARD_BITS 8

`endif

// ---- core/mdm_pkg.sv ----
package mdm_pkg;

    typedef logic [4:0] mdm_addr_t;
    typedef logic [15:0] mdm_data_t;

    typedef enum logic [8:0] {
        TGT_IDLE = 9'h001,
        TGT_START = 9'h002,
        TGT_OP = 9'h004,
        TGT_PHY = 9'h008,
        TGT_REG = 9'h010,
        TGT_TA = 9'h020,
        TGT_RD = 9'h040,
        TGT_WR = 9'h080,
        TGT_SKIP = 9'h100
    } mdm_tgt_e;

    typedef enum logic [2:0] {
        STA_GUARD = 3'h1,
        STA_IDLE = 3'h2,
        STA_RUN = 3'h4
    } mdm_sta_e;

endpackage

// ---- core/mdm_if.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Two-wire management link; the pull-up makes an undriven line read as one.
interface mdm_if;
    logic mdc;
    logic sta_o;
    logic sta_oe;
    logic dev_o;
    logic dev_oe;
    logic mdio;

    // Wired line: the enabled driver sets the level; the device wins if both ends enable theirs.
    assign mdio = dev_oe ? dev_o : (sta_oe ? sta_o : 1'b1);

    modport dev (input mdc, input mdio, output dev_o, output dev_oe);
    modport management_station (output mdc, output sta_o, output sta_oe, input mdio);
endinterface

// ---- core/mdm_target.sv ----
`timescale 1ns/100ps
`include "mdm_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// R01 - Station sources management clock, max 25MHz.
// R02 - Works with management clock stopped when idle.
// R03 - Receiver samples data line on rising clock.
// R04 - Idle and undriven turnaround release the line.
// R05 - Answer only frames carrying own address.
// R06 - Address straps captured during reset, then held.
// R07 - Station keeps bus idle after reset.
// R08 - Register field selects one of 32 words.
// R09 - Frame recognised only on zero-one start.
// R10 - Nobody drives first read turnaround bit.
// R11 - Device drives zero, then read data.
// R12 - Station drives write turnaround one-zero, data.
// R13 - Fixed field order; read opcode one-zero.
// R14 - Write opcode zero-one, MSB first, others ignored.
// R15 - Driver disabled outside own read data phase.
module mdm_target (
    input wire logic core_clk,
    input wire logic srst,
    mdm_if.dev link,
    input wire logic [4:0] management_address_straps,
    output mdm_pkg::mdm_addr_t own_addr,
    output logic wr_stb,
    output mdm_pkg::mdm_addr_t wr_addr,
    output mdm_pkg::mdm_data_t wr_data
);
    import mdm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Core clock domain state.
    logic [4:0] strap_s1;
    logic [4:0] strap_s2;
    logic lrst_req;
    logic ack_s1;
    logic ack_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic next_lrst_req;
    logic next_wr_stb;
    mdm_addr_t next_own_addr;
    mdm_addr_t next_wr_addr;
    mdm_data_t next_wr_data;

    // Link clock domain state.
    logic rst_s1;
    logic rst_s2;
    mdm_addr_t addr_s1;
    mdm_addr_t addr_s2;
    mdm_tgt_e state;
    mdm_tgt_e next_state;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [1:0] op;
    logic [1:0] next_op;
    mdm_addr_t pa;
    mdm_addr_t next_pa;
    mdm_addr_t ra;
    mdm_addr_t next_ra;
    mdm_data_t shift;
    mdm_data_t next_shift;
    mdm_data_t rdbuf;
    mdm_data_t next_rdbuf;
    logic oe;
    logic next_oe;
    logic dout;
    logic next_dout;
    logic tog;
    logic next_tog;
    mdm_addr_t hold_addr;
    mdm_addr_t next_hold_addr;
    mdm_data_t hold_data;
    mdm_data_t next_hold_data;
    logic next_we;
    mdm_data_t regs [`MDM_NREG];
    logic bit_in;
    mdm_addr_t ra_full;
    logic is_read;
    logic is_write;
    logic tog_edge;

    ////////////////////////////////////////////////////////////////////////////
    // A toggle seen while the link side is still leaving reset is noise, not a write.
    assign tog_edge = (tog_s2 ^ tog_s3) && !lrst_req && !ack_s2;

    // Core side: the link reset request stays up until the link side has seen it,
    // so it works however late the first management clock edge arrives.
    always_comb
    begin
        next_lrst_req = lrst_req;
        next_own_addr = own_addr;
        next_wr_stb = tog_edge;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        if (srst)
        begin
            next_lrst_req = 1'b1; // R02
            next_own_addr = strap_s2; // R06
        end
        else if (ack_s2)
        begin
            next_lrst_req = 1'b0;
        end
        // The held word is stable long before the toggle arrives here.
        if (tog_edge)
        begin
            next_wr_addr = hold_addr;
            next_wr_data = hold_data;
        end
    end

    // Core side registers and synchronisers.
    always_ff @(posedge core_clk)
    begin
        strap_s1 <= management_address_straps;
        strap_s2 <= strap_s1;
        if (srst)
        begin
            lrst_req <= 1'b1;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
            own_addr <= next_own_addr;
            wr_stb <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 16'h0000;
        end
        else
        begin
            lrst_req <= next_lrst_req;
            ack_s1 <= rst_s2;
            ack_s2 <= ack_s1;
            tog_s1 <= tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
            own_addr <= next_own_addr;
            wr_stb <= next_wr_stb;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side: every decision is taken on a rising management clock edge.
    assign bit_in = link.mdio; // R03
    assign ra_full = {ra[3:0], bit_in};
    assign is_read = (op == `MDM_OP_READ) && (pa == addr_s2); // R05 R13
    assign is_write = (op == `MDM_OP_WRITE) && (pa == addr_s2); // R05 R14
    assign link.dev_o = dout;
    assign link.dev_oe = oe;

    // Frame decoder and read driver.
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_op = op;
        next_pa = pa;
        next_ra = ra;
        next_shift = shift;
        next_rdbuf = rdbuf;
        next_oe = 1'b0; // R04 R15
        next_dout = 1'b1;
        next_tog = tog;
        next_hold_addr = hold_addr;
        next_hold_data = hold_data;
        next_we = 1'b0;
        unique case (state)
            TGT_IDLE:
            begin
                if (!bit_in)
                begin
                    next_state = TGT_START;
                end
            end
            TGT_START:
            begin
                // Only a one after the zero opens a frame.
                if (bit_in)
                begin
                    next_state = TGT_OP; // R09
                    next_cnt = 5'h00;
                end
            end
            TGT_OP:
            begin
                next_op = {op[0], bit_in}; // R14
                next_cnt = cnt + 5'h01;
                if (cnt == 5'h01)
                begin
                    next_state = TGT_PHY;
                    next_cnt = 5'h00;
                end
            end
            TGT_PHY:
            begin
                next_pa = {pa[3:0], bit_in};
                next_cnt = cnt + 5'h01;
                if (cnt == 5'(`MDM_ADDR_W - 1))
                begin
                    next_state = TGT_REG;
                    next_cnt = 5'h00;
                end
            end
            TGT_REG:
            begin
                next_ra = ra_full;
                next_cnt = cnt + 5'h01;
                if (cnt == 5'(`MDM_ADDR_W - 1))
                begin
                    next_cnt = 5'h00;
                    next_rdbuf = regs[ra_full]; // R08
                    if (is_read || is_write)
                    begin
                        next_state = TGT_TA;
                    end
                    else
                    begin
                        next_state = TGT_SKIP; // R05 R14
                    end
                end
            end
            TGT_TA:
            begin
                next_cnt = 5'h00;
                if (cnt == 5'h00)
                begin
                    // First turnaround bit is floating; drive zero for the second.
                    next_cnt = 5'h01;
                    if (is_read)
                    begin
                        next_oe = 1'b1; // R10 R11
                        next_dout = 1'b0; // R11
                    end
                end
                else if (is_read)
                begin
                    next_oe = 1'b1;
                    next_dout = rdbuf[15]; // R11
                    next_rdbuf = {rdbuf[14:0], 1'b0};
                    next_state = TGT_RD;
                end
                else
                begin
                    next_state = TGT_WR; // R12
                end
            end
            TGT_RD:
            begin
                next_cnt = cnt + 5'h01;
                if (cnt == 5'(`MDM_DATA_W - 1))
                begin
                    // Release on the edge that samples the last bit.
                    next_state = TGT_IDLE; // R15
                end
                else
                begin
                    next_oe = 1'b1;
                    next_dout = rdbuf[15];
                    next_rdbuf = {rdbuf[14:0], 1'b0};
                end
            end
            TGT_WR:
            begin
                next_shift = {shift[14:0], bit_in}; // R14
                next_cnt = cnt + 5'h01;
                if (cnt == 5'(`MDM_DATA_W - 1))
                begin
                    next_we = 1'b1; // R08
                    next_hold_addr = ra;
                    next_hold_data = {shift[14:0], bit_in};
                    next_tog = ~tog;
                    next_state = TGT_IDLE;
                end
            end
            TGT_SKIP:
            begin
                // Foreign or unknown frames are counted out without a reply.
                next_cnt = cnt + 5'h01;
                if (cnt == 5'(`MDM_SKIP_BITS - 1))
                begin
                    next_state = TGT_IDLE;
                end
            end
            default:
            begin
                next_state = TGT_IDLE;
            end
        endcase
    end

    // Link side registers; the reset arrives through the request handshake.
    always_ff @(posedge link.mdc)
    begin
        rst_s1 <= lrst_req;
        rst_s2 <= rst_s1;
        addr_s1 <= own_addr;
        addr_s2 <= addr_s1;
        if (rst_s2)
        begin
            state <= TGT_IDLE;
            cnt <= 5'h00;
            op <= 2'h0;
            pa <= 5'h00;
            ra <= 5'h00;
            shift <= 16'h0000;
            rdbuf <= 16'h0000;
            oe <= 1'b0;
            dout <= 1'b1;
            tog <= 1'b0;
            hold_addr <= 5'h00;
            hold_data <= 16'h0000;
            for (int i = 0; i < `MDM_NREG; i++)
            begin
                regs[i] <= 16'h0000;
            end
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            op <= next_op;
            pa <= next_pa;
            ra <= next_ra;
            shift <= next_shift;
            rdbuf <= next_rdbuf;
            oe <= next_oe;
            dout <= next_dout;
            tog <= next_tog;
            hold_addr <= next_hold_addr;
            hold_data <= next_hold_data;
            if (next_we)
            begin
                regs[next_hold_addr] <= next_hold_data;
            end
        end
    end

endmodule

// ---- core/mdm_station.sv ----
`timescale 1ns/100ps
`include "mdm_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Management station: builds frames and makes the management clock by division.
module mdm_station (
    input wire logic core_clk,
    input wire logic srst,
    mdm_if.management_station link,
    input wire logic req,
    input wire logic req_write,
    input wire mdm_pkg::mdm_addr_t req_phy,
    input wire mdm_pkg::mdm_addr_t req_reg,
    input wire mdm_pkg::mdm_data_t req_wdata,
    output logic busy,
    output logic done,
    output mdm_pkg::mdm_data_t rdata
);
    import mdm_pkg::*;

    mdm_sta_e state;
    mdm_sta_e next_state;
    logic [2:0] ph;
    logic [2:0] next_ph;
    logic [6:0] bidx;
    logic [6:0] next_bidx;
    logic [64:0] tx;
    logic [64:0] next_tx;
    logic [64:0] en;
    logic [64:0] next_en;
    logic wr;
    logic next_wr;
    logic mdc;
    logic next_mdc;
    logic mdo;
    logic next_mdo;
    logic moe;
    logic next_moe;
    logic next_busy;
    logic next_done;
    mdm_data_t next_rdata;
    logic rx_s1;
    logic rx_s2;
    logic [6:0] last;

    assign link.mdc = mdc;
    assign link.sta_o = mdo;
    assign link.sta_oe = moe;
    assign last = (state == STA_GUARD) ? 7'(`MDM_GUARD_BITS - 1) : 7'(`MDM_FRAME_BITS - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Bit sequencer: new bit on the falling clock, sample on the rising one.
    always_comb
    begin
        next_state = state;
        next_ph = ph;
        next_bidx = bidx;
        next_tx = tx;
        next_en = en;
        next_wr = wr;
        next_mdc = mdc;
        next_mdo = mdo;
        next_moe = moe;
        next_busy = busy;
        next_done = 1'b0;
        next_rdata = rdata;
        unique case (state)
            STA_IDLE:
            begin
                // The clock is parked low here, so the last high phase is a full half period.
                next_mdc = 1'b0; // R02
                if (req)
                begin
                    next_state = STA_RUN;
                    next_busy = 1'b1;
                    next_wr = req_write;
                    next_ph = 3'h0;
                    next_bidx = 7'h00;
                    next_tx = {{`MDM_PRE_BITS{1'b1}}, `MDM_START_CODE,
                               req_write ? `MDM_OP_WRITE : `MDM_OP_READ, req_phy, req_reg,
                               req_write ? `MDM_TA_WRITE : `MDM_TA_READ, req_wdata, 1'b1};
                    next_en = req_write ? {{64{1'b1}}, 1'b0}
                                        : {{(`MDM_PRE_BITS + `MDM_HDR_BITS){1'b1}}, 19'h00000};
                end
            end
            STA_GUARD, STA_RUN:
            begin
                next_ph = (ph == 3'(`MDM_MDC_DIV - 1)) ? 3'h0 : ph + 3'h1;
                if (ph == 3'h0)
                begin
                    next_mdc = 1'b0;
                    next_mdo = tx[64];
                    next_moe = en[64];
                    next_tx = {tx[63:0], 1'b1};
                    next_en = {en[63:0], 1'b0};
                end
                if (ph == 3'(`MDM_MDC_HALF))
                begin
                    next_mdc = 1'b1;
                    if ((state == STA_RUN) && !wr && (bidx >= 7'(`MDM_RD_FIRST)) && (bidx <= 7'(`MDM_RD_LAST)))
                    begin
                        next_rdata = {rdata[14:0], rx_s2};
                    end
                end
                if (ph == 3'(`MDM_MDC_DIV - 1))
                begin
                    next_bidx = bidx + 7'h01;
                    if (bidx == last)
                    begin
                        next_state = STA_IDLE;
                        next_bidx = 7'h00;
                        next_moe = 1'b0;
                        next_busy = 1'b0;
                        next_done = (state == STA_RUN);
                    end
                end
            end
            default:
            begin
                next_state = STA_IDLE;
            end
        endcase
    end

    // Registers; reset starts the idle guard with the line released.
    always_ff @(posedge core_clk)
    begin
        rx_s1 <= link.mdio;
        rx_s2 <= rx_s1;
        if (srst)
        begin
            state <= STA_GUARD;
            ph <= 3'h0;
            bidx <= 7'h00;
            tx <= {65{1'b1}};
            en <= 65'h0;
            wr <= 1'b0;
            mdc <= 1'b0;
            mdo <= 1'b1;
            moe <= 1'b0;
            busy <= 1'b1;
            done <= 1'b0;
            rdata <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            ph <= next_ph;
            bidx <= next_bidx;
            tx <= next_tx;
            en <= next_en;
            wr <= next_wr;
            mdc <= next_mdc;
            mdo <= next_mdo;
            moe <= next_moe;
            busy <= next_busy;
            done <= next_done;
            rdata <= next_rdata;
        end
    end

endmodule

// ---- verification/mdm_link_properties.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Watches the shared management link from the outside.
module mdm_link_properties #(
    parameter logic [4:0] OWN_ADDR = 5'h00
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic mdc,
    input wire logic sta_o,
    input wire logic sta_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic mdio
);
    logic [5:0] fidx;
    logic [11:0] hdr;
    logic [5:0] ones;
    logic last;
    logic rd;
    logic hit;

    // Tracks the bit position that each rising edge samples, zero outside frames.
    always_ff @(posedge mdc or posedge srst)
    begin
        if (srst)
        begin
            fidx <= 6'h00;
            hdr <= 12'h000;
            ones <= 6'h00;
            last <= 1'b1;
        end
        else
        begin
            last <= (fidx == 6'h00) ? mdio : 1'b1;
            if (mdio)
                ones <= (ones == 6'h3F) ? ones : ones + 6'h01;
            else
                ones <= 6'h00;
            if (fidx >= 6'h02 && fidx <= 6'h0D)
                hdr <= {hdr[10:0], mdio};
            if (fidx == 6'h1F)
                fidx <= 6'h00;
            else if (fidx != 6'h00)
                fidx <= fidx + 6'h01;
            else if (!last && mdio)
                fidx <= 6'h02;
        end
    end

    // Header decode, valid from the turnaround to the next frame.
    assign rd = (hdr[11:10] == 2'h2);
    assign hit = (hdr[9:5] == OWN_ADDR);

    ////////////////////////////////////////////////////////////////////////////////
    property p_no_contention;
        @(posedge mdc) disable iff (srst) !(dev_oe && sta_oe);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("both ends drive the line");
    property p_ta_release;
        @(posedge mdc) disable iff (srst) (fidx == 6'h0E && rd) |-> (mdio && !sta_oe);
    endproperty
    a_ta_release: assert property (p_ta_release)
        else $error("first read turnaround bit not released");
    property p_ta_zero;
        @(posedge mdc) disable iff (srst) (fidx == 6'h0E && rd && hit) |-> ##1 (dev_oe && !mdio);
    endproperty
    a_ta_zero: assert property (p_ta_zero)
        else $error("second read turnaround bit not driven low");
    property p_data_driven;
        @(posedge mdc) disable iff (srst) (fidx >= 6'h10 && rd && hit) |-> (dev_oe && !sta_oe);
    endproperty
    a_data_driven: assert property (p_data_driven)
        else $error("read data not driven by the target");
    property p_oe_scope;
        @(posedge mdc) disable iff (srst) dev_oe |-> (rd && hit && fidx >= 6'h0F);
    endproperty
    a_oe_scope: assert property (p_oe_scope)
        else $error("target drives outside its own read data");
    property p_preamble;
        @(posedge mdc) disable iff (srst) (fidx == 6'h00 && sta_oe && !mdio) |-> (ones >= 6'h20);
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("start code without full preamble");
    property p_write_ta;
        @(posedge mdc) disable iff (srst) (fidx == 6'h0E && hdr[11:10] == 2'h1) |-> mdio ##1 !mdio;
    endproperty
    a_write_ta: assert property (p_write_ta)
        else $error("write turnaround is not one then zero");
    property p_opcode;
        @(posedge mdc) disable iff (srst) (fidx == 6'h04) |-> (hdr[1:0] == 2'h2 || hdr[1:0] == 2'h1);
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("station sent an unknown operation code");
    property p_mdc_rate;
        @(posedge core_clk) disable iff (srst) $rose(mdc) |-> mdc[*3] ##1 !mdc[*3];
    endproperty
    a_mdc_rate: assert property (p_mdc_rate)
        else $error("management clock phase too short");
    property p_sta_change_low;
        @(posedge core_clk) disable iff (srst) ($changed(sta_o) || $changed(sta_oe)) |-> !mdc;
    endproperty
    a_sta_change_low: assert property (p_sta_change_low)
        else $error("station data changed while the clock is high");
    property p_reset_quiet;
        @(posedge core_clk) disable iff (srst) $fell(srst) |-> (!sta_oe)[*8];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("station drove the line right after reset");
endmodule

// ---- verification/mdio_management_target_tb.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Station and target joined by one link; results are checked against a register model.
module mdio_management_target_tb;
    import mdm_pkg::*;

    localparam logic [4:0] OWN_ADDR = 5'h0B;
    localparam int LIMIT = 30000;

    logic core_clk;
    logic srst;
    logic req;
    logic req_write;
    mdm_addr_t req_phy;
    mdm_addr_t req_reg;
    mdm_data_t req_wdata;
    logic busy;
    logic done;
    mdm_data_t rdata;
    logic [4:0] management_address_straps;
    mdm_addr_t own_addr;
    logic wr_stb;
    mdm_addr_t wr_addr;
    mdm_data_t wr_data;
    mdm_data_t mem [32];
    logic [16:0] exp_rd [$];
    logic [20:0] exp_wr [$];
    logic [16:0] e_rd;
    logic [20:0] e_wr;
    mdm_addr_t rg;
    mdm_data_t d;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 50568;
    int n;

    mdm_if link_if ();

    mdm_station mdm_station_inst (.core_clk(core_clk), .srst(srst), .link(link_if), .req(req),
        .req_write(req_write), .req_phy(req_phy), .req_reg(req_reg), .req_wdata(req_wdata),
        .busy(busy), .done(done), .rdata(rdata));

    mdm_target mdm_target_inst (.core_clk(core_clk), .srst(srst), .link(link_if),
        .management_address_straps(management_address_straps), .own_addr(own_addr),
        .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));

    mdm_link_properties #(.OWN_ADDR(OWN_ADDR)) mdm_link_properties_inst (.core_clk(core_clk),
        .srst(srst), .mdc(link_if.mdc), .sta_o(link_if.sta_o), .sta_oe(link_if.sta_oe),
        .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe), .mdio(link_if.mdio));

    ////////////////////////////////////////////////////////////////////////////////
    // Counts a comparison and reports a mismatch at once.
    task automatic report(input logic ok, input logic [20:0] got, input logic [20:0] exp);
        compares++;
        if (!ok)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_read(input mdm_data_t got, input mdm_data_t exp);
        report(got === exp, 21'(got), 21'(exp));
    endtask

    task automatic check_write(input logic [20:0] got, input logic [20:0] exp);
        report(got === exp, got, exp);
    endtask

    task automatic check_addr(input mdm_addr_t got, input mdm_addr_t exp);
        report(got === exp, 21'(got), 21'(exp));
    endtask

    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Waits until the station is free, hands it one frame and notes what must come back.
    task automatic frame(input logic w, input mdm_addr_t phy, input mdm_addr_t r, input mdm_data_t v);
        int k;
        begin
            k = 0;
            do
            begin
                @(posedge core_clk);
                #1;
                k++;
            end
            while (busy !== 1'b0 && k < 2000);
            @(posedge core_clk);
            req <= 1'b1;
            req_write <= w;
            req_phy <= phy;
            req_reg <= r;
            req_wdata <= v;
            @(posedge core_clk);
            req <= 1'b0;
            exp_rd.push_back({!w, (phy == OWN_ADDR) ? mem[r] : 16'hFFFF});
            if (w && phy == OWN_ADDR)
            begin
                exp_wr.push_back({r, v});
                mem[r] = v;
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard.
    always #4 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            conclude();
        end
    end

    // Station completions are matched to notes in issue order.
    always @(posedge core_clk)
    begin
        if (!srst && done === 1'b1)
        begin
            if (exp_rd.size() > 0)
            begin
                e_rd = exp_rd.pop_front();
                if (e_rd[16])
                    check_read(rdata, e_rd[15:0]);
            end
            else
                report(1'b0, 21'(rdata), 21'h000000);
        end
    end

    // Target write events are matched to notes; an unexpected one is a mismatch.
    always @(posedge core_clk)
    begin
        if (!srst && wr_stb === 1'b1)
        begin
            e_wr = (exp_wr.size() > 0) ? exp_wr.pop_front() : 21'h1FFFFF;
            check_write({wr_addr, wr_data}, e_wr);
        end
    end

    // Main sequence: reset, register traffic, foreign addresses, then the verdict.
    initial
    begin
        core_clk = 1'b0;
        srst = 1'b1;
        req = 1'b0;
        req_write = 1'b0;
        req_phy = 5'h00;
        req_reg = 5'h00;
        req_wdata = 16'h0000;
        management_address_straps = OWN_ADDR;
        for (n = 0; n < 32; n++)
            mem[n] = 16'h0000;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        management_address_straps <= 5'h14;
        frame(1'b0, OWN_ADDR, 5'h05, 16'h0000);
        for (n = 0; n < 12; n++)
        begin
            rg = (n == 0) ? 5'h00 : (n == 1) ? 5'h1F : 5'($random(seed));
            d = 16'($random(seed));
            frame(1'b1, OWN_ADDR, rg, d);
            frame(1'b0, OWN_ADDR, rg, 16'h0000);
        end
        frame(1'b1, OWN_ADDR, 5'h07, 16'hA5C3);
        frame(1'b1, OWN_ADDR ^ 5'h10, 5'h07, 16'h5A3C);
        frame(1'b0, OWN_ADDR ^ 5'h01, 5'h07, 16'h0000);
        frame(1'b0, OWN_ADDR, 5'h07, 16'h0000);
        repeat (800) @(posedge core_clk);
        check_addr(own_addr, OWN_ADDR);
        report(exp_rd.size() == 0 && exp_wr.size() == 0, 21'(exp_rd.size()), 21'h000000);
        conclude();
    end
endmodule
